// *** verilog/vrs_pkg.sv ***
// vrs_pkg: constants, register layout and carrier types for the
// voltage reference select bank and its per-source controllers.
// assumes a 32-bit AXI4-Lite register bus and word-aligned registers.
`default_nettype none

package vrs_pkg;

    // bus geometry
    localparam int VRS_ADDR_W = 8;
    localparam int VRS_DATA_W = 32;
    localparam int VRS_IDX_LSB = 2; // byte address is four times the index

    // register indices; byte address = index * 4
    localparam logic [7:0] VRS_IDX_CONV_IN = 8'h00;
    localparam logic [7:0] VRS_IDX_RSV_A = 8'h01;
    localparam logic [7:0] VRS_IDX_CONV_OUT = 8'h02;
    localparam logic [7:0] VRS_IDX_RSV_B = 8'h03;
    localparam logic [7:0] VRS_IDX_COMPARATOR = 8'h04;
    localparam logic [7:0] VRS_IDX_STATUS = 8'h05;

    // field positions and reset values
    localparam int VRS_FORCE_ON_BIT = 7;
    localparam int VRS_LEVEL_LSB = 0;
    localparam int VRS_LEVEL_W = 3;
    localparam logic [7:0] VRS_REF_RESET = 8'h00;
    localparam logic [7:0] VRS_REF_WMASK = 8'h87;
    localparam int VRS_STAT_CONV_IN_BIT = 0;
    localparam int VRS_STAT_CONV_OUT_BIT = 1;
    localparam int VRS_STAT_COMPARATOR_BIT = 2;

    // level select codes
    localparam logic [2:0] VRS_LVL_INTERNAL_LOW = 3'h0;
    localparam logic [2:0] VRS_LVL_INTERNAL_MID = 3'h1;
    localparam logic [2:0] VRS_LVL_INTERNAL_HIGH = 3'h2;
    localparam logic [2:0] VRS_LVL_INTERNAL_TWO_HALF = 3'h3;
    localparam logic [2:0] VRS_LVL_RESERVED_A = 3'h4;
    localparam logic [2:0] VRS_LVL_SUPPLY = 3'h5;
    localparam logic [2:0] VRS_LVL_EXTERNAL_PIN = 3'h6;
    localparam logic [2:0] VRS_LVL_RESERVED_B = 3'h7;

    // bus responses
    localparam logic [1:0] VRS_RESP_OKAY = 2'h0;
    localparam logic [1:0] VRS_RESP_SLVERR = 2'h2;

    // one reference control register as software sees it
    typedef struct packed {
        logic forceOn;
        logic [3:0] spare;
        logic [2:0] levelSelect;
    } vrs_cfg_t;

    // enable plus one-hot routing toward one analog consumer
    typedef struct packed {
        logic enable;
        logic internalLowLevel;
        logic internalMidLevel;
        logic internalHighLevel;
        logic internalTwoHalfLevel;
        logic supply;
        logic externalReferencePin;
    } vrs_ref_t;

    typedef enum logic [2:0] {
        VRS_BUS_IDLE = 3'b001,
        VRS_BUS_WRESP = 3'b010,
        VRS_BUS_RRESP = 3'b100
    } vrs_bus_st_t;

    // routing of one level code; reserved codes route nothing
    function automatic vrs_ref_t vrs_route(input logic en,
                                           input logic [2:0] lvl);
        vrs_ref_t r;
        r = '0;
        r.enable = en;
        if (en) begin
            unique case (lvl)
                VRS_LVL_INTERNAL_LOW: r.internalLowLevel = 1'b1;
                VRS_LVL_INTERNAL_MID: r.internalMidLevel = 1'b1;
                VRS_LVL_INTERNAL_HIGH: r.internalHighLevel = 1'b1;
                VRS_LVL_INTERNAL_TWO_HALF: r.internalTwoHalfLevel = 1'b1;
                VRS_LVL_SUPPLY: r.supply = 1'b1;
                VRS_LVL_EXTERNAL_PIN: r.externalReferencePin = 1'b1;
                VRS_LVL_RESERVED_A, VRS_LVL_RESERVED_B: r.enable = en;
            endcase
        end
        return r;
    endfunction : vrs_route

endpackage : vrs_pkg

`default_nettype wire

// *** verilog/vrs_source_ctrl.sv ***
// vrs_source_ctrl: enable and routing of one reference source.
// assumes request lines come from another clock domain or pins and
// that the config input is a flop of the register bank.
`timescale 1ns/1ns
`default_nettype none

module vrs_source_ctrl
    import vrs_pkg::*;
#(
    parameter int REQ_W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [REQ_W-1:0] request,
    input wire vrs_cfg_t cfg,
    output vrs_ref_t refOut
);

    typedef struct packed {
        logic [REQ_W-1:0] reqMeta;
        logic [REQ_W-1:0] reqSync;
        vrs_ref_t refOut;
    } vrs_src_state_t;

    vrs_src_state_t state_ff;
    vrs_src_state_t nxt_state;

    // sync then decide; shared sources need any one requester
    always_comb begin
        logic needed;
        needed = 1'b0;
        nxt_state = state_ff;
        nxt_state.reqMeta = request;
        nxt_state.reqSync = state_ff.reqMeta;
        needed = |state_ff.reqSync;
        nxt_state.refOut = vrs_route(cfg.forceOn | needed,
                                     cfg.levelSelect);
    end

    // single register stage for the whole state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign refOut = state_ff.refOut;

endmodule : vrs_source_ctrl

`default_nettype wire

// *** verilog/vrs_regs.sv ***
// vrs_regs: voltage reference select bank behind an AXI4-Lite slave.
// assumes a single master with at most one write and one read under
// way; request inputs are asynchronous to clk.
//
// Overview of operation
// - converter-in register, force bit 7, level 2:0
// - converter-out register at index 0x02, same layout
// - shared comparator register at index 0x04
// - force off: enable source only on request
// - force on: source always enabled
// - codes 0-3 route the four internal levels
// - code 5 supply, 6 external pin; 4,7 reserved
// - consumer request switches source on automatically
`timescale 1ns/1ns
`default_nettype none

module vrs_regs
    import vrs_pkg::*;
#(
    parameter int NUM_COMPARATORS = 3
) (
    input wire logic clk,
    input wire logic rst,
    // write address channel
    input wire logic [VRS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [VRS_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [VRS_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [VRS_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog consumers
    input wire logic convInRequest,
    input wire logic convOutRequest,
    input wire logic [NUM_COMPARATORS-1:0] comparatorRequest,
    output vrs_ref_t convInRef,
    output vrs_ref_t convOutRef,
    output vrs_ref_t comparatorRef
);

    // bus timing seen from the master, one write:
    // edge 0 takes address and data, readies drop
    // edge 1 commits the byte into the config flops
    // bvalid stands from edge 1 until the bready edge
    // reference outputs follow one edge after the commit
    // one read: rvalid stands from the edge that takes ar
    // no queue: a second request waits on the readies
    typedef struct packed {
        // bus sequencing and captured write halves
        vrs_bus_st_t st;
        logic awGot;
        logic wGot;
        logic [VRS_ADDR_W-1:0] wAddr;
        logic [7:0] wByte;
        logic wLane;
        // handshake and response flops driving the ports
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [VRS_DATA_W-1:0] rdata;
        logic [1:0] rresp;
        // software-visible configuration, one per source
        vrs_cfg_t cfgConvIn;
        vrs_cfg_t cfgConvOut;
        vrs_cfg_t cfgComparator;
    } vrs_regs_state_t;

    vrs_regs_state_t state_ff;
    vrs_regs_state_t nxt_state;
    vrs_ref_t convInRefInt;
    vrs_ref_t convOutRefInt;
    vrs_ref_t comparatorRefInt;

    // protection bits carry no meaning for this bank
    // every register sits in byte lane 0, so upper lanes and
    // upper data bits are dropped on purpose
    logic unusedProt;
    assign unusedProt = ^{s_axi_awprot, s_axi_arprot, s_axi_wstrb[3:1],
                          s_axi_wdata[VRS_DATA_W-1:8]};

    // word index of a byte address
    function automatic logic [7:0] wordIndex(
        input logic [VRS_ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = '0;
        idx[VRS_ADDR_W-VRS_IDX_LSB-1:0] = addr[VRS_ADDR_W-1:VRS_IDX_LSB];
        return idx;
    endfunction : wordIndex

    // writable and reserved-but-decoded indices answer OKAY
    function automatic logic isMapped(input logic [VRS_ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = wordIndex(addr);
        return idx <= VRS_IDX_STATUS;
    endfunction : isMapped

    // read mux; unused bits come back as stored zeros
    function automatic logic [VRS_DATA_W-1:0] readWord(
        input logic [VRS_ADDR_W-1:0] addr,
        input vrs_regs_state_t s,
        input logic [2:0] live);
        logic [VRS_DATA_W-1:0] d;
        d = '0;
        unique case (wordIndex(addr))
            VRS_IDX_CONV_IN: d[7:0] = s.cfgConvIn;
            VRS_IDX_CONV_OUT: d[7:0] = s.cfgConvOut;
            VRS_IDX_COMPARATOR: d[7:0] = s.cfgComparator;
            // status is live, taken from the enable flops
            VRS_IDX_STATUS: d[2:0] = live;
            default: d = '0;
        endcase
        return d;
    endfunction : readWord

    // bus handshakes and register writes
    always_comb begin
        logic awTake;
        logic wTake;
        logic arTake;
        logic [2:0] live;
        logic [7:0] wIdx;
        logic [7:0] masked;
        awTake = s_axi_awvalid & state_ff.awready;
        wTake = s_axi_wvalid & state_ff.wready;
        arTake = s_axi_arvalid & state_ff.arready;
        // status bits mirror the controllers' enable flops
        live = '0;
        live[VRS_STAT_CONV_IN_BIT] = convInRefInt.enable;
        live[VRS_STAT_CONV_OUT_BIT] = convOutRefInt.enable;
        live[VRS_STAT_COMPARATOR_BIT] = comparatorRefInt.enable;
        // the store works from the captured halves only
        wIdx = wordIndex(state_ff.wAddr);
        masked = state_ff.wByte & VRS_REF_WMASK;
        nxt_state = state_ff;
        unique case (state_ff.st)
            VRS_BUS_IDLE: begin
                // address and data may arrive in either order
                if (awTake) begin
                    nxt_state.awGot = 1'b1;
                    nxt_state.wAddr = s_axi_awaddr;
                end
                if (wTake) begin
                    nxt_state.wGot = 1'b1;
                    nxt_state.wByte = s_axi_wdata[7:0];
                    nxt_state.wLane = s_axi_wstrb[0];
                end
                if (arTake) begin
                    // read wins; a half-taken write waits for it
                    nxt_state.st = VRS_BUS_RRESP;
                    nxt_state.rvalid = 1'b1;
                    nxt_state.rdata = readWord(s_axi_araddr, state_ff, live);
                    nxt_state.rresp = isMapped(s_axi_araddr) ?
                        VRS_RESP_OKAY : VRS_RESP_SLVERR;
                end else if (state_ff.awGot && state_ff.wGot) begin
                    // both halves held: commit the low byte lane
                    nxt_state.st = VRS_BUS_WRESP;
                    nxt_state.bvalid = 1'b1;
                    nxt_state.bresp = isMapped(state_ff.wAddr) ?
                        VRS_RESP_OKAY : VRS_RESP_SLVERR;
                    if (state_ff.wLane) begin
                        unique case (wIdx)
                            VRS_IDX_CONV_IN:
                                nxt_state.cfgConvIn = vrs_cfg_t'(masked);
                            VRS_IDX_CONV_OUT:
                                nxt_state.cfgConvOut = vrs_cfg_t'(masked);
                            VRS_IDX_COMPARATOR:
                                nxt_state.cfgComparator =
                                    vrs_cfg_t'(masked);
                            default: begin
                                // reserved, status or unmapped word: nothing stored
                                nxt_state.bresp = nxt_state.bresp;
                            end
                        endcase
                    end
                end
            end
            VRS_BUS_WRESP: begin
                // halves are dropped only once the answer is taken
                if (s_axi_bready) begin
                    nxt_state.st = VRS_BUS_IDLE;
                    nxt_state.bvalid = 1'b0;
                    nxt_state.awGot = 1'b0;
                    nxt_state.wGot = 1'b0;
                end
            end
            VRS_BUS_RRESP: begin
                if (s_axi_rready) begin
                    nxt_state.st = VRS_BUS_IDLE;
                    nxt_state.rvalid = 1'b0;
                end
            end
        endcase
        // readies are registered, derived from where the state goes
        // a held write half blocks reads, so a store and a read
        // of the same word never overlap
        nxt_state.awready = (nxt_state.st == VRS_BUS_IDLE) &&
                            !nxt_state.awGot;
        nxt_state.wready = (nxt_state.st == VRS_BUS_IDLE) &&
                           !nxt_state.wGot;
        nxt_state.arready = (nxt_state.st == VRS_BUS_IDLE) &&
                            !nxt_state.awGot && !nxt_state.wGot;
    end

    // rst is asynchronous and loads every flop's reset value at once;
    // the first request after release needs no warm-up
    // whole state in one register; readies open after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= '{st: VRS_BUS_IDLE,
                          awGot: 1'b0,
                          wGot: 1'b0,
                          wAddr: '0,
                          wByte: 8'h00,
                          wLane: 1'b0,
                          awready: 1'b1,
                          wready: 1'b1,
                          arready: 1'b1,
                          bvalid: 1'b0,
                          bresp: VRS_RESP_OKAY,
                          rvalid: 1'b0,
                          rdata: '0,
                          rresp: VRS_RESP_OKAY,
                          cfgConvIn: vrs_cfg_t'(VRS_REF_RESET),
                          cfgConvOut: vrs_cfg_t'(VRS_REF_RESET),
                          cfgComparator: vrs_cfg_t'(VRS_REF_RESET)};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // bus outputs straight from the state register
    assign s_axi_awready = state_ff.awready;
    assign s_axi_wready = state_ff.wready;
    assign s_axi_arready = state_ff.arready;
    assign s_axi_bvalid = state_ff.bvalid;
    assign s_axi_bresp = state_ff.bresp;
    assign s_axi_rvalid = state_ff.rvalid;
    assign s_axi_rdata = state_ff.rdata;
    assign s_axi_rresp = state_ff.rresp;

    // requests cross two flops inside each controller, so a
    // source follows its request three edges late; force_on
    // avoids that start-up wait at the cost of standing power
    // one controller per consumer; comparators share one source
    vrs_source_ctrl #(
        .REQ_W(1)
    ) uConvIn (
        .clk(clk),
        .rst(rst),
        .request(convInRequest),
        .cfg(state_ff.cfgConvIn),
        .refOut(convInRefInt)
    );

    vrs_source_ctrl #(
        .REQ_W(1)
    ) uConvOut (
        .clk(clk),
        .rst(rst),
        .request(convOutRequest),
        .cfg(state_ff.cfgConvOut),
        .refOut(convOutRefInt)
    );

    vrs_source_ctrl #(
        .REQ_W(NUM_COMPARATORS)
    ) uComparator (
        .clk(clk),
        .rst(rst),
        .request(comparatorRequest),
        .cfg(state_ff.cfgComparator),
        .refOut(comparatorRefInt)
    );

    // consumer outputs are the controllers' own flops
    assign convInRef = convInRefInt;
    assign convOutRef = convOutRefInt;
    assign comparatorRef = comparatorRefInt;

endmodule : vrs_regs

`default_nettype wire

// *** tb/vrs_consumer_model.sv ***
// vrs_consumer_model: analog consumers that ask for a reference.
// assumes the bench sets want on rising edges; one flop of lag.
`timescale 1ns/1ns
`default_nettype none

module vrs_consumer_model #(
    parameter int NUM_COMPARATORS = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [NUM_COMPARATORS+1:0] want,
    output logic convInRequest,
    output logic convOutRequest,
    output logic [NUM_COMPARATORS-1:0] comparatorRequest
);
    // requests are levels held as long as the consumer converts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {comparatorRequest, convOutRequest, convInRequest} <= '0;
        end else begin
            {comparatorRequest, convOutRequest, convInRequest} <= want;
        end
    end
endmodule : vrs_consumer_model

`default_nettype wire

// *** tb/vrs_regs_chk.sv ***
// vrs_regs_chk: bus timing and reference output properties.
// assumes it is bound to vrs_regs and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module vrs_regs_chk
    import vrs_pkg::*;
#(
    parameter int NUM_COMPARATORS = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [VRS_DATA_W-1:0] s_axi_rdata,
    input wire logic convInRequest,
    input wire logic [NUM_COMPARATORS-1:0] comparatorRequest,
    input wire vrs_ref_t convInRef,
    input wire vrs_ref_t comparatorRef
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // take steps of one write and one read
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    chk_write_answer: assert property (wrTaken |-> ##2 s_axi_bvalid)
        else $error("write answer late or missing");
    chk_write_block: assert property (wrTaken |=> !s_axi_awready
        && !s_axi_wready && !s_axi_arready)
        else $error("bus not blocked during write");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write response not released");
    chk_read_answer: assert property (rdTaken |=> s_axi_rvalid
        && !s_axi_arready)
        else $error("read answer late or missing");
    chk_r_release: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready)
        else $error("read data not released");
    chk_rdata_zero: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == '0 && s_axi_rdata[6:3] == '0)
        else $error("unused read bits not zero");
    // three sampled request cycles cover the sync and output flops
    chk_req_on: assert property (convInRequest [*3] |=> convInRef.enable)
        else $error("request did not enable source");
    chk_cmp_req_on: assert property ((|comparatorRequest) [*3] |=>
        comparatorRef.enable)
        else $error("comparator request did not enable source");
    chk_route_onehot: assert property ($onehot0(convInRef[5:0])
        && $onehot0(comparatorRef[5:0]))
        else $error("more than one level routed");
    chk_route_gated: assert property (!convInRef.enable |->
        convInRef[5:0] == '0)
        else $error("level routed while source off");
endmodule : vrs_regs_chk

bind vrs_regs vrs_regs_chk #(.NUM_COMPARATORS(NUM_COMPARATORS)) i_chk (
    .clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .convInRequest, .comparatorRequest, .convInRef, .comparatorRef
);

`default_nettype wire

// *** tb/vrs_regs_tb.sv ***
// vrs_regs_tb: register bank and request scenarios for vrs_regs.
// assumes the checker is bound in and one AXI4-Lite master here.
`timescale 1ns/1ns
`default_nettype none

module vrs_regs_tb
    import vrs_pkg::*;
;
    localparam logic [1:0] OK = VRS_RESP_OKAY;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic [4:0] want = 5'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, convInRequest, convOutRequest;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [2:0] comparatorRequest;
    vrs_ref_t convInRef, convOutRef, comparatorRef;
    int miscompares = 0;
    int totalChecks = 0;

    always #20 clk = ~clk;

    // prot, strobes and ready lines are constant for this master
    vrs_regs i_dut (
        .clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'h1),
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready(1'h1), .convInRequest, .convOutRequest,
        .comparatorRequest, .convInRef, .convOutRef, .comparatorRef
    );
    vrs_consumer_model i_consumers (
        .clk, .rst, .want, .convInRequest, .convOutRequest,
        .comparatorRequest
    );

    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: word %h not %h", $time, got, exp);
        end
    endtask : checkWord

    task automatic checkRef(input vrs_ref_t got, input vrs_ref_t exp);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: ref %b not %b", $time, got, exp);
        end
    endtask : checkRef

    // both halves offered together; bounded wait for the response
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] er);
        int n;
        logic done, awTaken, wTaken;
        logic [1:0] resp;
        n = 0;
        done = 1'h0;
        resp = 2'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            // settled flop outputs mid-cycle are what the next edge sees
            @(negedge clk);
            n++;
            done = s_axi_bvalid;
            resp = s_axi_bresp;
            awTaken = s_axi_awready;
            wTaken = s_axi_wready;
            @(posedge clk);
            if (awTaken) s_axi_awvalid <= 1'h0;
            if (wTaken) s_axi_wvalid <= 1'h0;
        end while (!done && n < 50);
        checkWord({29'h0, done, resp}, {29'h0, 1'h1, er});
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] a, input logic [31:0] ed,
                           input logic [1:0] er);
        int n;
        logic done, arTaken;
        logic [31:0] data;
        logic [1:0] resp;
        n = 0;
        done = 1'h0;
        data = 32'h0;
        resp = 2'h0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(negedge clk);
            n++;
            done = s_axi_rvalid;
            data = s_axi_rdata;
            resp = s_axi_rresp;
            arTaken = s_axi_arready;
            @(posedge clk);
            if (arTaken) s_axi_arvalid <= 1'h0;
        end while (!done && n < 50);
        checkWord(data, ed);
        checkWord({29'h0, done, resp}, {29'h0, 1'h1, er});
    endtask : axiRead

    function automatic vrs_ref_t expRef(input logic en, input logic [2:0] lv);
        vrs_ref_t r;
        r = '0;
        r.enable = en;
        if (en && lv < 3'h4) r[5 - lv] = 1'h1;
        if (en && lv == 3'h5) r.supply = 1'h1;
        if (en && lv == 3'h6) r.externalReferencePin = 1'h1;
        return r;
    endfunction : expRef

    function automatic vrs_ref_t pick(input int i);
        return i == 0 ? convInRef : (i == 1 ? convOutRef : comparatorRef);
    endfunction : pick

    // reset contents of the three config and two reserved words, sources idle
    task automatic resetValues();
        @(negedge clk);
        for (int i = 0; i < 3; i++) checkRef(pick(i), '0);
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            axiRead(8'(i * 4), 32'h0, OK);
        end
    endtask : resetValues

    // wide writes: only force and level bits stick, rest reads zero
    task automatic fieldMask();
        for (int i = 0; i < 5; i++) begin
            axiWrite(8'(i * 4), 32'hFFFF_FFFE, OK);
            axiRead(8'(i * 4), i % 2 ? 32'h0 : 32'h86, OK);
        end
        axiRead(8'h14, 32'h7, OK);
        @(negedge clk);
        for (int i = 0; i < 3; i++) begin
            checkRef(pick(i), expRef(1'h1, 3'h6));
        end
        @(posedge clk);
        axiWrite(8'h18, 32'h85, VRS_RESP_SLVERR);
        axiRead(8'h18, 32'h0, VRS_RESP_SLVERR);
    endtask : fieldMask

    // every legal level on every source; reserved codes never written
    task automatic levels();
        for (int i = 0; i < 3; i++) begin
            for (int c = 0; c < 7; c++) begin
                if (c == 4) continue;
                axiWrite(8'(i * 8), 32'h80 | c, OK);
                @(negedge clk);
                checkRef(pick(i), expRef(1'h1, 3'(c)));
                @(posedge clk);
            end
        end
    endtask : levels

    // force cleared: each consumer request switches only its source
    task automatic requests();
        for (int i = 0; i < 3; i++) axiWrite(8'(i * 8), 32'h05, OK);
        for (int b = 0; b < 5; b++) begin
            @(posedge clk);
            want <= 5'(1 << b);
            repeat (4) @(posedge clk);
            @(negedge clk);
            for (int i = 0; i < 3; i++) begin
                checkRef(pick(i), expRef(i == (b < 2 ? b : 2), 3'h5));
            end
            @(posedge clk);
            axiRead(8'h14, b < 2 ? 32'(1 << b) : 32'h4, OK);
            want <= 5'h0;
            repeat (4) @(posedge clk);
            @(negedge clk);
            for (int i = 0; i < 3; i++) checkRef(pick(i), '0);
        end
    endtask : requests

    task automatic summarize();
        $display("checks %0d, mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // main sequence, reset held eight cycles
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        resetValues();
        fieldMask();
        levels();
        requests();
        summarize();
    end

    // hang guard; the sequence needs well under a thousand cycles
    initial begin
        #(40 * 5000);
        miscompares++;
        summarize();
    end
endmodule : vrs_regs_tb

`default_nettype wire
